// ### hdl/twrpc_consts.vh
/*
 Constants for the write reply parity checker: widths, timing figures
 in their own units and derived cycle counts at the 25 MHz clock.
 Assumes inclusion by bare name from the checker files.
*/
`ifndef TWRPC_CONSTS_VH
`define TWRPC_CONSTS_VH

// Tape line layout: six data bits plus parity in bit 6
`define TWRPC_LINE_W        7
`define TWRPC_PAR_BIT       6
`define TWRPC_CHAR_W        6
`define TWRPC_UNITS         4
`define TWRPC_SEL_W         2

// Clock rate in kHz, times in ns
`define TWRPC_CLK_KHZ       25000
`define TWRPC_PERIOD_NS     26000
`define TWRPC_PULSE_NS      1000
`define TWRPC_SKEW_NS       13000

// Least times round up, longest round down
`define TWRPC_PERIOD_CYC    ((`TWRPC_PERIOD_NS * `TWRPC_CLK_KHZ) / 1000000)
`define TWRPC_PULSE_CYC     ((`TWRPC_PULSE_NS * `TWRPC_CLK_KHZ + 999999) / 1000000)
`define TWRPC_SKEW_CYC      ((`TWRPC_SKEW_NS * `TWRPC_CLK_KHZ + 999999) / 1000000)
`define TWRPC_CNT_W         10

`endif

// ### hdl/twrpc_arrival.v
/*
 Line arrival detector for one tape unit's read channels.
 Assumes read amplifier outputs are synchronous to clk and
 return to zero between lines.
*/
`timescale 1ns/1ps
`include "twrpc_consts.vh"

module twrpc_arrival (
	// Clock and reset
	input  wire                     clk,
	input  wire                     rst_n,
	// Read amplifier bits
	input  wire [`TWRPC_LINE_W-1:0] bits,
	// First bit of a line seen
	output reg                      first_q
);

	reg  any_q;
	wire any_d;

	assign any_d = |bits;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			any_q   <= 1'b0;
			first_q <= 1'b0;
		end else begin
			any_q   <= any_d;
			first_q <= any_d & ~any_q;
		end
	end

endmodule // twrpc_arrival

// ### hdl/twrpc_check.v
/*
 Write reply parity checker: captures read-back lines from the
 selected tape unit, times the checking sequence and latches errors.
 Assumes unit select and format are steady while writing and the
 computer clears the error flag with err_clr.
*/
`timescale 1ns/1ps
`include "twrpc_consts.vh"

// Overview of operation
// - OR seven bits to detect line start
// - One arrival detector per tape unit
// - Load selected unit into reply register
// - Start 26 us sequence, 1 us pulses
// - Hold off check for skew interval
// - Binary: total ones must be odd
// - Coded: total ones must be even
module twrpc_check (
	// Clock and reset
	input  wire                                     clk,
	input  wire                                     rst_n,
	// Read amplifiers, all units packed
	input  wire [`TWRPC_UNITS*`TWRPC_LINE_W-1:0]    rd_bits,
	// Stored write selection
	input  wire [`TWRPC_SEL_W-1:0]                  unit_sel,
	input  wire                                     coded_fmt,
	input  wire                                     reply_en,
	// Error sense
	input  wire                                     err_clr,
	output reg                                      parity_err_q,
	// Sequence status
	output reg                                      busy_q,
	output reg                                      check_pulse_q,
	output reg  [`TWRPC_LINE_W-1:0]                 reply_line_register_q
);

	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_SKEW  = 3'h2;
	localparam [2:0] ST_CHECK = 3'h4;

	// Counts worked out at full width, then cut to the counter
	localparam integer PERIOD_N = `TWRPC_PERIOD_CYC - 1;
	localparam integer SKEW_N   = `TWRPC_SKEW_CYC - 1;
	localparam integer PULSE_N  = `TWRPC_SKEW_CYC + `TWRPC_PULSE_CYC - 1;

	localparam [`TWRPC_CNT_W-1:0]  PERIOD_LAST = PERIOD_N[`TWRPC_CNT_W-1:0];
	localparam [`TWRPC_CNT_W-1:0]  SKEW_LAST   = SKEW_N[`TWRPC_CNT_W-1:0];
	localparam [`TWRPC_CNT_W-1:0]  PULSE_LAST  = PULSE_N[`TWRPC_CNT_W-1:0];
	localparam [`TWRPC_CNT_W-1:0]  CNT_ZERO    = {`TWRPC_CNT_W{1'b0}};
	localparam [`TWRPC_CNT_W-1:0]  CNT_ONE     = {{(`TWRPC_CNT_W-1){1'b0}}, 1'b1};
	localparam [`TWRPC_LINE_W-1:0] LINE_ZERO   = {`TWRPC_LINE_W{1'b0}};

	wire [`TWRPC_UNITS-1:0]  first;
	reg  [`TWRPC_LINE_W-1:0] sel_bits;
	reg                      sel_first;
	reg  [2:0]               state_q;
	reg  [2:0]               state_d;
	reg  [`TWRPC_CNT_W-1:0]  cnt_q;
	reg  [`TWRPC_CNT_W-1:0]  cnt_d;
	reg                      busy_d;
	reg                      check_pulse_d;
	reg                      parity_err_d;
	reg  [`TWRPC_LINE_W-1:0] reply_line_register_d;
	wire                     ones_odd;
	wire                     bad;
	wire                     chk;
	wire                     pulse_end;

	genvar u;
	generate
		for (u = 0; u < `TWRPC_UNITS; u = u + 1) begin : g_unit
			twrpc_arrival twrpc_arrival_i (
				.clk     (clk),
				.rst_n   (rst_n),
				.bits    (rd_bits[u*`TWRPC_LINE_W +: `TWRPC_LINE_W]),
				.first_q (first[u])
			);
		end
	endgenerate

	always @* begin
		sel_bits  = rd_bits[unit_sel*`TWRPC_LINE_W +: `TWRPC_LINE_W];
		sel_first = first[unit_sel] & reply_en;
	end

	assign ones_odd = ^reply_line_register_q;
	assign bad = coded_fmt ? ones_odd : ~ones_odd;

	assign chk = (state_q == ST_SKEW) && (cnt_q == SKEW_LAST);
	assign pulse_end = (state_q == ST_CHECK) && (cnt_q == PULSE_LAST);

	// Next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (sel_first) begin
					state_d = ST_SKEW;
				end
			end
			ST_SKEW: begin
				if (chk) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (cnt_q == PERIOD_LAST) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @* begin
		if (state_q == ST_IDLE) begin
			cnt_d = CNT_ZERO;
		end else begin
			cnt_d = cnt_q + CNT_ONE;
		end
	end

	always @* begin
		busy_d = (state_d != ST_IDLE);
	end

	// load, then gather late bits
	// Gathering stops at the check so the register holds the judged line
	always @* begin
		reply_line_register_d = reply_line_register_q;
		if ((state_q == ST_IDLE) && sel_first) begin
			reply_line_register_d = sel_bits;
		end else if ((state_q == ST_SKEW) && !chk) begin
			reply_line_register_d = reply_line_register_q | sel_bits;
		end
	end

	always @* begin
		check_pulse_d = check_pulse_q;
		if (chk) begin
			check_pulse_d = 1'b1;
		end else if (pulse_end) begin
			check_pulse_d = 1'b0;
		end
	end

	// sticky error
	// Set wins over clear so no error is lost
	always @* begin
		parity_err_d = parity_err_q;
		if (chk && bad) begin
			parity_err_d = 1'b1;
		end else if (err_clr) begin
			parity_err_d = 1'b0;
		end
	end

	// Sequence state
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Period counter
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Busy status
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// Reply register
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reply_line_register_q <= LINE_ZERO;
		end else begin
			reply_line_register_q <= reply_line_register_d;
		end
	end

	// Check pulse
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			check_pulse_q <= 1'b0;
		end else begin
			check_pulse_q <= check_pulse_d;
		end
	end

	// Error flag
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			parity_err_q <= 1'b0;
		end else begin
			parity_err_q <= parity_err_d;
		end
	end

endmodule // twrpc_check

// ### tb/twrpc_chk.sv
/* Port checker for twrpc_check. Assumes bind below. */
`timescale 1ns/1ps
`include "twrpc_consts.vh"
module twrpc_chk (
	input wire clk, rst_n, err_clr, coded_fmt, parity_err_q, busy_q, check_pulse_q,
	input wire [27:0] rd_bits,
	input wire [1:0]  unit_sel,
	input wire [6:0]  reply_line_register_q
);
	wire [6:0] s = rd_bits[unit_sel*7+:7];
	wire [6:0] r = reply_line_register_q;
	wire       p = check_pulse_q;
	localparam int SKEW_LO = `TWRPC_SKEW_CYC - 1;
	localparam int SKEW_HI = `TWRPC_SKEW_CYC + 1;
	localparam int PER_LO  = `TWRPC_PERIOD_CYC - 1;
	localparam int PER_HI  = `TWRPC_PERIOD_CYC + 1;
	// Cycles since busy rose; long spans kept out of delays
	reg [9:0] age_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			age_q <= 10'h000;
		end else if (!busy_q) begin
			age_q <= 10'h000;
		end else begin
			age_q <= age_q + 10'h001;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_start_cause: assert property ($rose(busy_q) |-> ($past(s) | $past(s, 2)) != 0)
		else $error("start without bits");
	chk_reg_load: assert property ($rose(busy_q) |-> (r & ~$past(s)) == 0)
		else $error("foreign bits");
	chk_skew_hold: assert property (busy_q && age_q < SKEW_LO |-> !p)
		else $error("check too early");
	chk_check_time: assert property ($rose(p) |-> age_q >= SKEW_LO && age_q <= SKEW_HI)
		else $error("check time");
	chk_check_due: assert property (busy_q && age_q == SKEW_HI + 1 |-> p)
		else $error("check missing");
	chk_pulse_width: assert property ($rose(p) |-> ##23 p ##[1:3] !p)
		else $error("pulse width");
	chk_busy_len: assert property ($fell(busy_q) |-> age_q >= PER_LO && age_q <= PER_HI)
		else $error("period");
	chk_busy_end: assert property (busy_q |-> age_q <= PER_HI)
		else $error("period overrun");
	chk_err_hold: assert property (parity_err_q && !err_clr |=> parity_err_q)
		else $error("error lost");
	chk_bin_par: assert property ($rose(p) && !coded_fmt |-> parity_err_q >= !(^r))
		else $error("binary parity");
	chk_cod_par: assert property ($rose(p) && coded_fmt |-> parity_err_q >= (^r))
		else $error("coded parity");
	cover property ($rose(busy_q));
	cover property ($rose(parity_err_q));
	cover property ($rose(p) && coded_fmt);
endmodule // twrpc_chk
bind twrpc_check twrpc_chk twrpc_chk_i (.clk, .rst_n, .err_clr, .coded_fmt, .parity_err_q,
	.busy_q, .check_pulse_q, .rd_bits, .unit_sel, .reply_line_register_q);

// ### tb/twrpc_tape.sv
/* Read amplifiers of one unit; parity bit late by skew. Assumes one-cycle go. */
`timescale 1ns/1ps
module twrpc_tape (
	input wire       clk, go,
	input wire [6:0] line,
	input wire [9:0] skew,
	output wire [6:0] bits
);
	reg [9:0] n = 10'h384;
	// Amplifiers return to zero between lines
	assign bits = (n < 10'h190) ? {line[6] & (n >= skew), line[5:0]} : 7'h00;
	always @(posedge clk) n <= go ? 10'h000 : (n < 10'h384) ? n + 10'h001 : n;
endmodule // twrpc_tape

// ### tb/tape_write_reply_parity_check_tb.sv
/* Bench for twrpc_check. Assumes four twrpc_tape units. */
`timescale 1ns/1ps
module tape_write_reply_parity_check_tb;
	reg clk = 0, rst_n = 0, coded_fmt = 0, reply_en = 1, err_clr = 0;
	reg [1:0] unit_sel = 0;
	reg [3:0] go = 0;
	reg [27:0] ln = 0;
	reg [9:0] sk = 0;
	wire [27:0] rd_bits;
	wire parity_err_q, busy_q, check_pulse_q;
	wire [6:0] reply_line_register_q;
	integer fails = 0, n_compared = 0;
	genvar k;
	for (k = 0; k < 4; k = k + 1) begin : g
		twrpc_tape twrpc_tape_i (.clk, .go(go[k]), .line(ln[7*k+:7]), .skew(sk), .bits(rd_bits[7*k+:7]));
	end
	twrpc_check twrpc_check_i (.clk, .rst_n, .rd_bits, .unit_sel, .coded_fmt, .reply_en,
		.err_clr, .parity_err_q, .busy_q, .check_pulse_q, .reply_line_register_q);
	initial forever #20 clk = ~clk;
	task chk(input [6:0] a, input [6:0] b);
		begin
			n_compared = n_compared + 1;
			if (a !== b) begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h want %h", $time, a, b);
			end
		end
	endtask
	task send(input [1:0] u, input [6:0] l, input [9:0] s);
		reg [6:0] r;
		reg       on;
		begin
			// Late parity bit misses the check
			r = (s > 10'h145) ? l & 7'h3f : l;
			on = (u == unit_sel) && reply_en;
			sk = s;
			ln[7*u+:7] = l;
			go[u] = 1;
			@(negedge clk) go[u] = 0;
			repeat (5) @(negedge clk);
			chk(busy_q, on);
			chk(check_pulse_q, 0);
			repeat (330) @(negedge clk);
			chk(check_pulse_q, on);
			repeat (370) @(negedge clk);
			chk(busy_q, 0);
			if (on) chk(reply_line_register_q, r);
			chk(parity_err_q, on && (^r) == coded_fmt);
			err_clr = 1;
			@(negedge clk) err_clr = 0;
			chk(parity_err_q, 0);
		end
	endtask
	task t_bin;
		begin
			send(0, 7'h01, 0);
			send(0, 7'h03, 0);
		end
	endtask
	task t_cod;
		begin
			unit_sel = 2;
			coded_fmt = 1;
			send(2, 7'h41, 0);
			send(2, 7'h01, 0);
		end
	endtask
	task t_skw;
		begin
			unit_sel = 1;
			coded_fmt = 0;
			send(1, 7'h43, 10'h12c);
			send(1, 7'h43, 10'h154);
		end
	endtask
	task t_sel;
		begin
			unit_sel = 3;
			send(1, 7'h03, 0);
			send(3, 7'h03, 0);
			reply_en = 0;
			send(3, 7'h03, 0);
			reply_en = 1;
		end
	endtask
	task conclude;
		begin
			$display("fails=%0d n_compared=%0d", fails, n_compared);
			if (fails == 0 && n_compared > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		t_bin;
		t_cod;
		t_skw;
		t_sel;
		conclude;
	end
	initial begin
		#1000000;
		fails = fails + 1;
		conclude;
	end
endmodule // tape_write_reply_parity_check_tb
